//--- design/dlf_pkg.sv
// Constants shared by the loop-filter configuration register bank
package dlf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ACQ_IDX  = 8'h69;
  localparam logic [7:0] DAMP_IDX = 8'h6a;
  localparam logic [7:0] BW2_IDX  = 8'h66;
  localparam logic [7:0] CTRL_IDX = 8'h70;
  localparam logic [7:0] STAT_IDX = 8'h71;

  // Reset values
  localparam logic [7:0] ACQ_RST  = 8'h11;
  localparam logic [7:0] DAMP_RST = 8'h13;
  localparam logic [7:0] BW2_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Writable bits; the others keep their reset value
  localparam logic [7:0] ACQ_WMASK  = 8'h0f;
  localparam logic [7:0] DAMP_WMASK = 8'h77;
  localparam logic [7:0] BW2_WMASK  = 8'h03;
  localparam logic [7:0] CTRL_WMASK = 8'h03;

  // Field positions
  localparam int unsigned ACQ_BW_LSB   = 0;
  localparam int unsigned DAMP_LSB     = 0;
  localparam int unsigned GAIN_LSB     = 4;
  localparam int unsigned BW2_LSB      = 0;
  localparam int unsigned CTRL_AUTO    = 0;
  localparam int unsigned CTRL_GAIN_EN = 1;

  // First loop acquisition bandwidth codes
  localparam logic [1:0] L1_BW_18  = 2'h3;
  localparam logic [1:0] L1_BW_35  = 2'h0;
  localparam logic [1:0] L1_BW_70  = 2'h1;
  localparam logic [1:0] L1_BW_RSV = 2'h2;

  // Second loop bandwidth codes
  localparam logic [1:0] L2_BW_18  = 2'h0;
  localparam logic [1:0] L2_BW_35  = 2'h1;
  localparam logic [1:0] L2_BW_70  = 2'h2;
  localparam logic [1:0] L2_BW_RSV = 2'h3;

  // Damping codes
  localparam logic [2:0] DAMP_C1 = 3'h1;
  localparam logic [2:0] DAMP_C2 = 3'h2;
  localparam logic [2:0] DAMP_C3 = 3'h3;
  localparam logic [2:0] DAMP_C4 = 3'h4;
  localparam logic [2:0] DAMP_C5 = 3'h5;

  // Damping factor in tenths, zero for a reserved code
  localparam logic [7:0] DF_NONE = 8'h00;
  localparam logic [7:0] DF_1P2  = 8'h0c;
  localparam logic [7:0] DF_2P5  = 8'h19;
  localparam logic [7:0] DF_5    = 8'h32;
  localparam logic [7:0] DF_10   = 8'h64;
  localparam logic [7:0] DF_20   = 8'hc8;

  // Gain peak in hundredths of a dB
  localparam logic [7:0] PK_NONE = 8'h00;
  localparam logic [7:0] PK_040  = 8'h28;
  localparam logic [7:0] PK_020  = 8'h14;
  localparam logic [7:0] PK_010  = 8'h0a;
  localparam logic [7:0] PK_006  = 8'h06;
  localparam logic [7:0] PK_003  = 8'h03;

endpackage : dlf_pkg

//--- design/dlf_damping_decode.sv
// Damping code and bandwidth to damping factor and gain peak
`timescale 1ns/1ps
module dlf_damping_decode
  import dlf_pkg::*;
(
  input  wire logic [2:0] dampCode,
  input  wire logic [1:0] bwCode,
  output logic      [7:0] factor,
  output logic      [7:0] peak,
  output logic            reserved
);

  always_comb begin
    factor   = DF_NONE;
    reserved = (bwCode == L2_BW_RSV);
    case (dampCode)
      DAMP_C1: factor = DF_1P2;
      DAMP_C2: factor = DF_2P5;
      DAMP_C3: factor = DF_5;
      DAMP_C4: factor = (bwCode == L2_BW_18) ? DF_5 : DF_10;
      DAMP_C5: begin
        case (bwCode)
          L2_BW_18: factor = DF_5;
          L2_BW_35: factor = DF_10;
          default:  factor = DF_20;
        endcase
      end
      default: reserved = 1'b1;
    endcase
    // Reserved bandwidth gives no meaningful factor
    if (reserved) begin
      factor = DF_NONE;
    end
  end

  always_comb begin
    case (factor)
      DF_1P2:  peak = PK_040;
      DF_2P5:  peak = PK_020;
      DF_5:    peak = PK_010;
      DF_10:   peak = PK_006;
      DF_20:   peak = PK_003;
      default: peak = PK_NONE;
    endcase
  end

endmodule : dlf_damping_decode

//--- design/dlf_apb_slave.sv
// APB slave front end: zero-wait answer, registered read data
`timescale 1ns/1ps
module dlf_apb_slave
  import dlf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  pstrb,
  input  wire logic        regHit,
  input  wire logic [7:0]  rdData,
  output logic             wrStrobe,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
    logic        err;
  } dlf_apb_s;

  dlf_apb_s apb_reg;
  dlf_apb_s apb_next;

  // Data is captured in the setup cycle, so the access phase never waits
  always_comb begin
    apb_next = '0;
    if (psel && !penable) begin
      apb_next.ready = 1'b1;
      apb_next.err   = !regHit;
      apb_next.rdata = (regHit && !pwrite) ? {24'h000000, rdData} : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      apb_reg <= '0;
    end else begin
      apb_reg <= apb_next;
    end
  end

  // Only the low lane carries register bits
  assign wrStrobe = psel && penable && apb_reg.ready && pwrite && pstrb[0] && regHit;
  assign pready   = apb_reg.ready;
  assign prdata   = apb_reg.rdata;
  assign pslverr  = apb_reg.err;

  // pready is high the cycle after a setup and low the cycle after that, unless the middle cycle was also a setup
  chk_apb_zero_wait : assert property (@(posedge core_clk) disable iff (!rstn)
    psel && !penable |=> pready ##1 (!pready || $past(psel && !penable)))
    else $error("APB answer not given in the access cycle");

endmodule : dlf_apb_slave

//--- design/dlf_loop_filter_cfg.sv
// Loop-filter configuration register bank for the two digital PLLs
//
// How it works
// - The first loop acquisition bandwidth (11=18 Hz, 00=35 Hz, 01=70 Hz, 10 unused) applies while unlocked, under the auto-switch bit.
// - The second loop damping code maps to a factor by bandwidth: 001=1.2, 010=2.5, 011=5, 100=5/10/10, 101=5/10/20.
// - Each damping factor carries a gain peak: 1.2=0.4 dB, 2.5=0.2 dB, 5=0.1 dB, 10=0.06 dB, 20=0.03 dB.
// - The second loop detector analog gain in bits 6:4 takes effect only with the gain enable set.
// - The second loop bandwidth field selects 00=18 Hz, 01=35 Hz, 10=70 Hz, 11 unused.
`timescale 1ns/1ps
module dlf_loop_filter_cfg
  import dlf_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  input  wire logic              loop1Locked,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic [1:0]             loop1AcqBwSel,
  output logic                   loop1AcqBwApply,
  output logic [1:0]             loop2BwSel,
  output logic [7:0]             loop2DampFactor,
  output logic [7:0]             loop2GainPeak,
  output logic [2:0]             loop2DetGain,
  output logic                   loop2DetGainApply
);

  typedef struct packed {
    logic [7:0] acqReg;
    logic [7:0] dampReg;
    logic [7:0] bw2Reg;
    logic [7:0] ctrlReg;
    logic [1:0] acqSel;
    logic       acqApply;
    logic [1:0] bw2Sel;
    logic [7:0] dampFactor;
    logic [7:0] gainPeak;
    logic [2:0] detGain;
    logic       detGainApply;
  } dlf_state_s;

  dlf_state_s cfg_reg;
  dlf_state_s cfg_next;

  logic       wrStrobe;
  logic       regHit;
  logic [7:0] rdData;
  logic [7:0] regIdx;
  logic       addrAligned;
  logic [7:0] decFactor;
  logic [7:0] decPeak;
  logic       dampReserved;
  logic [7:0] statusWord;
  logic       acqReserved;
  logic       bw2Reserved;
  logic [7:0] wrByte;

  // Index sits above the two byte bits; upper bits must be clear
  assign regIdx      = paddr[9:2];
  assign addrAligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign wrByte      = pwdata[7:0];

  always_comb begin
    regHit = 1'b0;
    if (addrAligned) begin
      case (regIdx)
        ACQ_IDX:  regHit = 1'b1;
        DAMP_IDX: regHit = 1'b1;
        BW2_IDX:  regHit = 1'b1;
        CTRL_IDX: regHit = 1'b1;
        STAT_IDX: regHit = 1'b1;
        default:  regHit = 1'b0;
      endcase
    end
  end

  assign acqReserved = (cfg_reg.acqReg[ACQ_BW_LSB +: 2] == L1_BW_RSV);
  assign bw2Reserved = (cfg_reg.bw2Reg[BW2_LSB +: 2] == L2_BW_RSV);

  // Live view of the block, for software to check what the loops see
  assign statusWord = {3'h0,
                       loop1Locked,
                       cfg_reg.acqApply,
                       bw2Reserved,
                       dampReserved,
                       acqReserved};

  always_comb begin
    case (regIdx)
      ACQ_IDX:  rdData = cfg_reg.acqReg;
      DAMP_IDX: rdData = cfg_reg.dampReg;
      BW2_IDX:  rdData = cfg_reg.bw2Reg;
      CTRL_IDX: rdData = cfg_reg.ctrlReg;
      STAT_IDX: rdData = statusWord;
      default:  rdData = 8'h00;
    endcase
  end

  dlf_apb_slave u_apb (
    .core_clk (core_clk),
    .rstn     (rstn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pstrb    (pstrb),
    .regHit   (regHit),
    .rdData   (rdData),
    .wrStrobe (wrStrobe),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr)
  );

  // Decode from the stored fields, so outputs follow a write by two cycles
  dlf_damping_decode u_damp (
    .dampCode (cfg_reg.dampReg[DAMP_LSB +: 3]),
    .bwCode   (cfg_reg.bw2Reg[BW2_LSB +: 2]),
    .factor   (decFactor),
    .peak     (decPeak),
    .reserved (dampReserved)
  );

  always_comb begin
    cfg_next = cfg_reg;

    // Masked merge: bits outside the mask never change
    if (wrStrobe) begin
      case (regIdx)
        ACQ_IDX: begin
          cfg_next.acqReg = (cfg_reg.acqReg & ~ACQ_WMASK) | (wrByte & ACQ_WMASK);
        end
        DAMP_IDX: begin
          cfg_next.dampReg = (cfg_reg.dampReg & ~DAMP_WMASK) | (wrByte & DAMP_WMASK);
        end
        BW2_IDX: begin
          cfg_next.bw2Reg = (cfg_reg.bw2Reg & ~BW2_WMASK) | (wrByte & BW2_WMASK);
        end
        CTRL_IDX: begin
          cfg_next.ctrlReg = (cfg_reg.ctrlReg & ~CTRL_WMASK) | (wrByte & CTRL_WMASK);
        end
        default: begin
          cfg_next.ctrlReg = cfg_reg.ctrlReg;
        end
      endcase
    end

    // Without auto switching the acquisition figure stays in force
    cfg_next.acqSel   = cfg_reg.acqReg[ACQ_BW_LSB +: 2];
    cfg_next.acqApply = !cfg_reg.ctrlReg[CTRL_AUTO] || !loop1Locked;

    cfg_next.bw2Sel     = cfg_reg.bw2Reg[BW2_LSB +: 2];
    cfg_next.dampFactor = decFactor;
    cfg_next.gainPeak   = decPeak;

    // Gain field is held back until software enables it
    cfg_next.detGainApply = cfg_reg.ctrlReg[CTRL_GAIN_EN];
    cfg_next.detGain      = cfg_reg.ctrlReg[CTRL_GAIN_EN] ?
                            cfg_reg.dampReg[GAIN_LSB +: 3] : 3'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_reg              <= '0;
      cfg_reg.acqReg       <= ACQ_RST;
      cfg_reg.dampReg      <= DAMP_RST;
      cfg_reg.bw2Reg       <= BW2_RST;
      cfg_reg.ctrlReg      <= CTRL_RST;
      cfg_reg.acqSel       <= ACQ_RST[ACQ_BW_LSB +: 2];
      cfg_reg.acqApply     <= 1'b1;
      cfg_reg.bw2Sel       <= BW2_RST[BW2_LSB +: 2];
      cfg_reg.dampFactor   <= DF_5;
      cfg_reg.gainPeak     <= PK_010;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign loop1AcqBwSel     = cfg_reg.acqSel;
  assign loop1AcqBwApply   = cfg_reg.acqApply;
  assign loop2BwSel        = cfg_reg.bw2Sel;
  assign loop2DampFactor   = cfg_reg.dampFactor;
  assign loop2GainPeak     = cfg_reg.gainPeak;
  assign loop2DetGain      = cfg_reg.detGain;
  assign loop2DetGainApply = cfg_reg.detGainApply;

  default clocking dlf_cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_acq_write_lands : assert property (
    wrStrobe && regIdx == ACQ_IDX |=> cfg_reg.acqReg[3:0] == $past(pwdata[3:0])
    ##1 loop1AcqBwSel == $past(pwdata[1:0], 2))
    else $error("Acquisition bandwidth write not reflected on output");

  chk_acq_auto_locked : assert property (
    cfg_reg.ctrlReg[CTRL_AUTO] && loop1Locked |=> !loop1AcqBwApply)
    else $error("Acquisition bandwidth applied while locked with auto switch");

  chk_acq_unlocked_on : assert property (
    !loop1Locked |=> loop1AcqBwApply)
    else $error("Acquisition bandwidth not applied while unlocked");

  chk_damp_flat_code : assert property (
    cfg_reg.dampReg[2:0] == DAMP_C2 && !bw2Reserved |=> loop2DampFactor == DF_2P5)
    else $error("Damping code 010 not decoded to 2.5");

  chk_damp_top_code : assert property (
    cfg_reg.dampReg[2:0] == DAMP_C5 && cfg_reg.bw2Reg[1:0] == L2_BW_70
    |=> loop2DampFactor == DF_20)
    else $error("Damping code 101 at 70 Hz not decoded to 20");

  chk_damp_low_bw : assert property (
    cfg_reg.dampReg[2:0] == DAMP_C4 && cfg_reg.bw2Reg[1:0] == L2_BW_18
    |=> loop2DampFactor == DF_5)
    else $error("Damping code 100 at 18 Hz not decoded to 5");

  chk_peak_pairs : assert property (
    loop2DampFactor == DF_10 |-> loop2GainPeak == PK_006)
    else $error("Gain peak does not match damping factor 10");

  chk_peak_half : assert property (
    loop2DampFactor == DF_1P2 |-> loop2GainPeak == PK_040)
    else $error("Gain peak does not match damping factor 1.2");

  chk_gain_gated : assert property (
    !cfg_reg.ctrlReg[CTRL_GAIN_EN] |=> loop2DetGain == 3'h0 && !loop2DetGainApply)
    else $error("Detector gain passed without enable");

  chk_gain_passes : assert property (
    cfg_reg.ctrlReg[CTRL_GAIN_EN] |=> loop2DetGain == $past(cfg_reg.dampReg[6:4]))
    else $error("Detector gain field not passed when enabled");

  chk_bw2_follows : assert property (
    wrStrobe && regIdx == BW2_IDX |=> ##1 loop2BwSel == $past(pwdata[1:0], 2))
    else $error("Second loop bandwidth write not reflected on output");

  chk_unused_hold : assert property (
    wrStrobe |=> cfg_reg.dampReg[7] == 1'b0 && cfg_reg.dampReg[3] == 1'b0
    && cfg_reg.acqReg[7:4] == $past(cfg_reg.acqReg[7:4]))
    else $error("Unused register bit changed by a write");

endmodule : dlf_loop_filter_cfg

//--- sim/tb.sv
// Self-checking bench for the loop-filter configuration register bank
`timescale 1ns/1ps
module tb;
  import dlf_pkg::*;

  typedef struct {
    logic [2:0] dc;
    logic [1:0] bw;
    logic [7:0] f;
    logic [7:0] p;
  } dlf_row_s;

  logic        core_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        loop1Locked;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [1:0]  loop1AcqBwSel;
  logic        loop1AcqBwApply;
  logic [1:0]  loop2BwSel;
  logic [7:0]  loop2DampFactor;
  logic [7:0]  loop2GainPeak;
  logic [2:0]  loop2DetGain;
  logic        loop2DetGainApply;
  int          fails;
  int          checks_done;
  logic [31:0] rdv;
  logic        rde;

  // Ordinary and reserved cases: damping code and bandwidth against factor and peak
  dlf_row_s rows [18] = '{
    '{3'h1, 2'h0, DF_1P2, PK_040}, '{3'h1, 2'h1, DF_1P2, PK_040}, '{3'h1, 2'h2, DF_1P2, PK_040},
    '{3'h2, 2'h0, DF_2P5, PK_020}, '{3'h2, 2'h1, DF_2P5, PK_020}, '{3'h2, 2'h2, DF_2P5, PK_020},
    '{3'h3, 2'h0, DF_5, PK_010},   '{3'h3, 2'h1, DF_5, PK_010},   '{3'h3, 2'h2, DF_5, PK_010},
    '{3'h4, 2'h0, DF_5, PK_010},   '{3'h4, 2'h1, DF_10, PK_006},  '{3'h4, 2'h2, DF_10, PK_006},
    '{3'h5, 2'h0, DF_5, PK_010},   '{3'h5, 2'h1, DF_10, PK_006},  '{3'h5, 2'h2, DF_20, PK_003},
    '{3'h0, 2'h0, DF_NONE, PK_NONE}, '{3'h6, 2'h1, DF_NONE, PK_NONE},
    '{3'h1, 2'h3, DF_NONE, PK_NONE}
  };

  dlf_loop_filter_cfg u_dut (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .loop1Locked      (loop1Locked),
    .pready           (pready),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .loop1AcqBwSel    (loop1AcqBwSel),
    .loop1AcqBwApply  (loop1AcqBwApply),
    .loop2BwSel       (loop2BwSel),
    .loop2DampFactor  (loop2DampFactor),
    .loop2GainPeak    (loop2GainPeak),
    .loop2DetGain     (loop2DetGain),
    .loop2DetGainApply(loop2DetGainApply)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // One APB transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("wrong value pready expected 1 seen timeout");
    end
    rdv = prdata;
    rde = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'h1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("prdata", rdv, exp);
    chk("pslverr", {31'h0, rde}, {31'h0, err});
  endtask : rd

  // Outputs follow the registers one edge after the write lands
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    loop1Locked = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    settle();
    chk("acq bw", {30'h0, loop1AcqBwSel}, 32'h1);
    chk("damp", {24'h0, loop2DampFactor}, {24'h0, DF_5});
    chk("peak", {24'h0, loop2GainPeak}, {24'h0, PK_010});
    rd(12'h1a4, 32'h11, 1'b0);
    rd(12'h1a8, 32'h13, 1'b0);
    rd(12'h198, 32'h00, 1'b0);
    foreach (rows[i]) begin
      wr(12'h198, {6'h0, rows[i].bw});
      wr(12'h1a8, {5'h0, rows[i].dc});
      settle();
      chk("bw2", {30'h0, loop2BwSel}, {30'h0, rows[i].bw});
      chk("damp", {24'h0, loop2DampFactor}, {24'h0, rows[i].f});
      chk("peak", {24'h0, loop2GainPeak}, {24'h0, rows[i].p});
    end
    // Every acquisition code, the unused one included, is passed through
    for (int c = 0; c < 4; c++) begin
      wr(12'h1a4, 8'(c));
      settle();
      chk("acq bw", {30'h0, loop1AcqBwSel}, 32'(c));
      // Unused acquisition code, reserved bandwidth and damping all flagged
      if (c == 2) begin
        rd(12'h1c4, 32'h0f, 1'b0);
      end
    end
    @(posedge core_clk);
    loop1Locked <= 1'b1;
    settle();
    chk("acq apply", {31'h0, loop1AcqBwApply}, 32'h1);
    wr(12'h1c0, 8'h01);
    settle();
    chk("acq apply", {31'h0, loop1AcqBwApply}, 32'h0);
    rd(12'h1c4, 32'h16, 1'b0);
    @(posedge core_clk);
    loop1Locked <= 1'b0;
    settle();
    chk("acq apply", {31'h0, loop1AcqBwApply}, 32'h1);
    wr(12'h1a8, 8'h53);
    settle();
    chk("det gain", {29'h0, loop2DetGain}, 32'h0);
    wr(12'h1c0, 8'h03);
    settle();
    chk("det gain", {29'h0, loop2DetGain}, 32'h5);
    chk("gain apply", {31'h0, loop2DetGainApply}, 32'h1);
    rd(12'h1a8, 32'h53, 1'b0);
    rd(12'h1c0, 32'h03, 1'b0);
    // Unused bits hold their reset value whatever is written
    wr(12'h1a4, 8'hff);
    rd(12'h1a4, 32'h1f, 1'b0);
    wr(12'h1a8, 8'hff);
    rd(12'h1a8, 32'h77, 1'b0);
    wr(12'h198, 8'hff);
    rd(12'h198, 32'h03, 1'b0);
    apb(1'b1, 12'h198, 32'h0, 4'h0);
    rd(12'h198, 32'h03, 1'b0);
    apb(1'b1, 12'h200, 32'hff, 4'h1);
    chk("wr err", {31'h0, rde}, 32'h1);
    rd(12'h200, 32'h0, 1'b1);
    // Second reset in mid-run restores defaults
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    settle();
    chk("gain apply", {31'h0, loop2DetGainApply}, 32'h0);
    rd(12'h1a8, 32'h13, 1'b0);
    close_out();
  end
endmodule : tb
